// ==== ccp_share_map.svh ====
// Register offsets, field positions, reset values for the two-unit capture/compare block.
// Assumes inclusion by the top module and the bench.
`ifndef CCP_SHARE_MAP_SVH
`define CCP_SHARE_MAP_SVH
`define OFF_U1_CTRL   8'h00
`define OFF_U1_LOW    8'h04
`define OFF_U1_HIGH   8'h08
`define OFF_U2_CTRL   8'h0C
`define OFF_U2_LOW    8'h10
`define OFF_U2_HIGH   8'h14
`define OFF_IRQ_STAT  8'h18
`define OFF_IRQ_MASK  8'h1C
`define OFF_CONFIG    8'h20
`define OFF_STATUS    8'h24
`define CFG_PINSEL_BIT 0
`define CFG_ADCEN_BIT  1
`define CFG_T1ASYNC_BIT 2
`define CFG_RESET_VAL 8'h01
`define MODE_OFF      4'h0
`define MODE_CAP_F    4'h4
`define MODE_CAP_R    4'h5
`define MODE_CMP_HI   4'h8
`define MODE_CMP_LO   4'h9
`define MODE_CMP_TG   4'h2
`define MODE_CMP_SW   4'hA
`define MODE_CMP_SE   4'hB
`define RESP_OKAY     2'b00
`define RESP_SLVERR   2'b10
`endif

// ==== ccp_share_pkg.sv ====
// Types for the two-unit capture/compare/PWM timer-sharing block.
// Assumes the map header supplies the numeric constants.
package ccp_share_pkg;
  typedef enum logic [1:0] {
    GRP_OFF  = 2'b00,
    GRP_CAPT = 2'b01,
    GRP_CMP  = 2'b10,
    GRP_PWM  = 2'b11
  } group_type;
  typedef struct packed {
    logic [3:0] mode;
    logic [7:0] low;
    logic [7:0] high;
  } unit_type;
  typedef struct packed {
    logic       resetFirst;
    logic       convStart;
  } trig_type;
endpackage

// ==== ccp_timer_resource_share.sv ====
// Control, timer sharing and compare/capture event logic for two units.
// Assumes AXI4-Lite master on clk; timers count outside and take a reset pulse.
`timescale 1ns/100ps
`include "ccp_share_map.svh"

module ccp_timer_resource_share
  import ccp_share_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [15:0] sharedCaptureTimer,
  input  wire logic        pwmPeriodEvent,
  input  wire logic        unitOnePinIn,
  input  wire logic        unitTwoPinIn,
  output logic             unitOnePinOut,
  output logic             portCAltPinOut,
  output logic             portBAltPinOut,
  output logic             firstTimerReset,
  output logic             convStart,
  output logic             pwmPeriodUpdate,
  output logic [1:0]       timerGroupOne,
  output logic [1:0]       timerGroupTwo,
  output logic             irq
);
  import ccp_share_pkg::*;

  function automatic group_type groupOf(input logic [3:0] m);
    if (m == `MODE_OFF || m[3:1] == 3'b001 && m[0])
      groupOf = GRP_OFF;
    else if (m[3:2] == 2'b11)
      groupOf = GRP_PWM;
    else if (m[3:2] == 2'b01)
      groupOf = GRP_CAPT;
    else
      groupOf = GRP_CMP;
  endfunction

  function automatic logic capEdge(input logic [3:0] m, input logic prv, input logic cur);
    capEdge = m[0] ? (!prv && cur) : (prv && !cur);
  endfunction

  unit_type   u1_q, u1_d, u2_q, u2_d;
  logic [7:0] cfg_q, cfg_d;
  logic [1:0] stat_q, stat_d, mask_q, mask_d;
  logic       awGot_q, awGot_d, wGot_q, wGot_d, bv_q, bv_d, rv_q, rv_d;
  logic [7:0] awA_q, awA_d;
  logic [31:0] wD_q, wD_d, rd_q, rd_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic [1:0] pinOne_q, pinOne_d, pinTwo_q, pinTwo_d;
  logic       s1b_q, s2b_q;
  logic       pc_q, pc_d, pb_q, pb_d;
  logic [1:0] tg1_q, tg1_d, tg2_q, tg2_d;
  logic [15:0] tmrPrev_q;
  logic       out1_q, out1_d, out2_q, out2_d;
  logic       rstT_q, rstT_d, conv_q, conv_d, pwmU_q, pwmU_d, irq_q, irq_d;
  logic       awr_q, awr_d, wr_q, wr_d, arr_q, arr_d;
  group_type  g1, g2;
  logic       match1, match2, cap1, cap2, se1, se2, ev1, ev2, wrFire;

  always_comb
  begin
    g1 = groupOf(u1_q.mode);
    g2 = groupOf(u2_q.mode);
    match1 = g1 == GRP_CMP && tmrPrev_q != sharedCaptureTimer &&
             sharedCaptureTimer == {u1_q.high, u1_q.low};
    match2 = g2 == GRP_CMP && tmrPrev_q != sharedCaptureTimer &&
             sharedCaptureTimer == {u2_q.high, u2_q.low};
    // Async counting cannot be sampled safely, so capture stays off then
    cap1 = g1 == GRP_CAPT && !cfg_q[`CFG_T1ASYNC_BIT] &&
           capEdge(u1_q.mode, s1b_q, pinOne_q[1]);
    cap2 = g2 == GRP_CAPT && !cfg_q[`CFG_T1ASYNC_BIT] &&
           capEdge(u2_q.mode, s2b_q, pinTwo_q[1]);
    se1 = match1 && u1_q.mode == `MODE_CMP_SE;
    se2 = match2 && u2_q.mode == `MODE_CMP_SE;
    ev1 = match1 || cap1;
    ev2 = match2 || cap2;
    wrFire = awGot_q && wGot_q && !bv_q;
  end

  always_comb
  begin
    u1_d = u1_q;
    u2_d = u2_q;
    cfg_d = cfg_q;
    mask_d = mask_q;
    stat_d = stat_q;
    awGot_d = awGot_q; wGot_d = wGot_q; awA_d = awA_q; wD_d = wD_q;
    bv_d = bv_q; bresp_d = bresp_q; rv_d = rv_q; rd_d = rd_q; rresp_d = rresp_q;
    if (s_axi_awvalid && awr_q)
    begin
      awGot_d = 1'b1;
      awA_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && wr_q)
    begin
      wGot_d = 1'b1;
      wD_d = s_axi_wdata;
    end
    // Both captures read the one shared timer, so stamps taken in the same cycle agree
    if (cap1)
      {u1_d.high, u1_d.low} = sharedCaptureTimer;
    if (cap2)
      {u2_d.high, u2_d.low} = sharedCaptureTimer;
    if (wrFire)
    begin
      awGot_d = 1'b0;
      wGot_d = 1'b0;
      bv_d = 1'b1;
      bresp_d = `RESP_OKAY;
      case (awA_q)
        `OFF_U1_CTRL:  u1_d.mode = wD_q[3:0];
        `OFF_U1_LOW:   u1_d.low = wD_q[7:0];
        `OFF_U1_HIGH:  u1_d.high = wD_q[7:0];
        `OFF_U2_CTRL:  u2_d.mode = wD_q[3:0];
        `OFF_U2_LOW:   u2_d.low = wD_q[7:0];
        `OFF_U2_HIGH:  u2_d.high = wD_q[7:0];
        `OFF_IRQ_STAT: stat_d = stat_q & ~wD_q[1:0];
        `OFF_IRQ_MASK: mask_d = wD_q[1:0];
        `OFF_CONFIG:   cfg_d = {5'h00, wD_q[2:0]};
        `OFF_STATUS:   bresp_d = `RESP_OKAY;
        default:       bresp_d = `RESP_SLVERR;
      endcase
    end
    // Set wins over a write-one clear in the same cycle; both flags survive
    stat_d = stat_d | {ev2, ev1};
    if (bv_q && s_axi_bready)
      bv_d = 1'b0;
    if (rv_q && s_axi_rready)
      rv_d = 1'b0;
    if (s_axi_arvalid && arr_q)
    begin
      rv_d = 1'b1;
      rresp_d = `RESP_OKAY;
      case (s_axi_araddr)
        `OFF_U1_CTRL:  rd_d = {28'h0000000, u1_q.mode};
        `OFF_U1_LOW:   rd_d = {24'h000000, u1_q.low};
        `OFF_U1_HIGH:  rd_d = {24'h000000, u1_q.high};
        `OFF_U2_CTRL:  rd_d = {28'h0000000, u2_q.mode};
        `OFF_U2_LOW:   rd_d = {24'h000000, u2_q.low};
        `OFF_U2_HIGH:  rd_d = {24'h000000, u2_q.high};
        `OFF_IRQ_STAT: rd_d = {30'h00000000, stat_q};
        `OFF_IRQ_MASK: rd_d = {30'h00000000, mask_q};
        `OFF_CONFIG:   rd_d = {24'h000000, cfg_q};
        `OFF_STATUS:   rd_d = {26'h0000000, out2_q, out1_q, g2, g1};
        default:
        begin
          rd_d = 32'h00000000;
          rresp_d = `RESP_SLVERR;
        end
      endcase
    end
    awr_d = !awGot_d && !(s_axi_awvalid && awr_q);
    wr_d = !wGot_d && !(s_axi_wvalid && wr_q);
    arr_d = !rv_d && !(s_axi_arvalid && arr_q);
  end

  always_comb
  begin
    out1_d = out1_q;
    out2_d = out2_q;
    if (u1_q.mode == `MODE_OFF)
      out1_d = 1'b0;
    if (u2_q.mode == `MODE_OFF)
      out2_d = 1'b0;
    if (match1)
      case (u1_q.mode)
        `MODE_CMP_HI: out1_d = 1'b1;
        `MODE_CMP_LO: out1_d = 1'b0;
        `MODE_CMP_TG: out1_d = !out1_q;
        default:      out1_d = out1_q;
      endcase
    if (match2)
      case (u2_q.mode)
        `MODE_CMP_HI: out2_d = 1'b1;
        `MODE_CMP_LO: out2_d = 1'b0;
        `MODE_CMP_TG: out2_d = !out2_q;
        default:      out2_d = out2_q;
      endcase
    // One pulse whichever unit fires, so a shared reset clears once
    rstT_d = se1 || se2;
    conv_d = se2 && cfg_q[`CFG_ADCEN_BIT];
    // The PWM period tick is common to both PWM units by construction
    pwmU_d = pwmPeriodEvent && (g1 == GRP_PWM || g2 == GRP_PWM);
    irq_d = |(stat_d & mask_d);
    pinOne_d = {pinOne_q[0], unitOnePinIn};
    pinTwo_d = {pinTwo_q[0], unitTwoPinIn};
    // Registered so pins and group codes leave straight from flops
    pc_d = cfg_d[`CFG_PINSEL_BIT] & out2_d;
    pb_d = !cfg_d[`CFG_PINSEL_BIT] & out2_d;
    tg1_d = u1_d.mode[3:2] == 2'b11 ? 2'b10 : 2'b01;
    tg2_d = u2_d.mode[3:2] == 2'b11 ? 2'b10 : 2'b01;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      u1_q <= '0; u2_q <= '0; cfg_q <= `CFG_RESET_VAL; stat_q <= 2'b00; mask_q <= 2'b00;
      awGot_q <= 1'b0; wGot_q <= 1'b0; awA_q <= 8'h00; wD_q <= 32'h00000000;
      bv_q <= 1'b0; bresp_q <= 2'b00; rv_q <= 1'b0; rd_q <= 32'h00000000; rresp_q <= 2'b00;
      awr_q <= 1'b0; wr_q <= 1'b0; arr_q <= 1'b0;
      pinOne_q <= 2'b00; pinTwo_q <= 2'b00; s1b_q <= 1'b0; s2b_q <= 1'b0;
      tmrPrev_q <= 16'h0000; out1_q <= 1'b0; out2_q <= 1'b0;
      rstT_q <= 1'b0; conv_q <= 1'b0; pwmU_q <= 1'b0; irq_q <= 1'b0;
      pc_q <= 1'b0; pb_q <= 1'b0; tg1_q <= 2'b01; tg2_q <= 2'b01;
    end
    else
    begin
      u1_q <= u1_d; u2_q <= u2_d; cfg_q <= cfg_d; stat_q <= stat_d; mask_q <= mask_d;
      awGot_q <= awGot_d; wGot_q <= wGot_d; awA_q <= awA_d; wD_q <= wD_d;
      bv_q <= bv_d; bresp_q <= bresp_d; rv_q <= rv_d; rd_q <= rd_d; rresp_q <= rresp_d;
      awr_q <= awr_d; wr_q <= wr_d; arr_q <= arr_d;
      pinOne_q <= pinOne_d; pinTwo_q <= pinTwo_d;
      s1b_q <= pinOne_q[1]; s2b_q <= pinTwo_q[1];
      tmrPrev_q <= sharedCaptureTimer; out1_q <= out1_d; out2_q <= out2_d;
      rstT_q <= rstT_d; conv_q <= conv_d; pwmU_q <= pwmU_d; irq_q <= irq_d;
      pc_q <= pc_d; pb_q <= pb_d; tg1_q <= tg1_d; tg2_q <= tg2_d;
    end
  end

  assign s_axi_awready = awr_q;
  assign s_axi_wready = wr_q;
  assign s_axi_bvalid = bv_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arr_q;
  assign s_axi_rvalid = rv_q;
  assign s_axi_rdata = rd_q;
  assign s_axi_rresp = rresp_q;
  assign unitOnePinOut = out1_q;
  // Pin choice only steers the output; direction stays with software
  assign portCAltPinOut = pc_q;
  assign portBAltPinOut = pb_q;
  assign firstTimerReset = rstT_q;
  assign convStart = conv_q;
  assign pwmPeriodUpdate = pwmU_q;
  assign timerGroupOne = tg1_q;
  assign timerGroupTwo = tg2_q;
  assign irq = irq_q;

  a_se_reset_once: assert property (@(posedge clk) disable iff (rst)
    (se1 && se2) |=> firstTimerReset ##1 (!firstTimerReset || $past(se1 || se2)))
    else $error("shared reset not a single pulse");
  a_conv_needs_en: assert property (@(posedge clk) disable iff (rst)
    convStart |-> $past(se2) && $past(cfg_q[`CFG_ADCEN_BIT]))
    else $error("conversion without unit two trigger");
  a_unit1_no_conv: assert property (@(posedge clk) disable iff (rst)
    (se1 && !se2) |=> !convStart)
    else $error("unit one launched a conversion");
  a_match_sets_flag: assert property (@(posedge clk) disable iff (rst)
    match1 |=> stat_q[0])
    else $error("compare match did not set flag");
  a_sw_mode_pin: assert property (@(posedge clk) disable iff (rst)
    (match1 && u1_q.mode == `MODE_CMP_SW) |=> $stable(out1_q))
    else $error("software interrupt mode moved the pin");
  a_special_reset: assert property (@(posedge clk) disable iff (rst)
    se1 |=> firstTimerReset)
    else $error("special event did not reset timer");
  a_async_no_cap: assert property (@(posedge clk) disable iff (rst)
    (cfg_q[`CFG_T1ASYNC_BIT] && !wrFire) |=> $stable(u1_q) && $stable(u2_q))
    else $error("capture while timer asynchronous");
  a_pin_route: assert property (@(posedge clk) disable iff (rst)
    !cfg_q[`CFG_PINSEL_BIT] |-> !portCAltPinOut)
    else $error("unit two output on wrong pin");
  a_pwm_isolated: assert property (@(posedge clk) disable iff (rst)
    (g1 == GRP_PWM && !se2) |=> !firstTimerReset)
    else $error("PWM units disturbed first timer");
endmodule

// ==== shared_timer_model.sv ====
// Far-side model: first shared timer count and second timer period pulse.
// Assumes one clock; the bench drives run and clr, the block drives timerReset.
`timescale 1ns/100ps
module shared_timer_model
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        run,
  input  wire logic        clr,
  input  wire logic        timerReset,
  output logic [15:0]      timerCount,
  output logic             periodEvent
);
  logic [15:0] count_q;
  logic [2:0]  div_q;
  assign timerCount = count_q;
  always_ff @(posedge clk)
  begin
    if (rst || clr || timerReset)  // Special event clears the first timer count
      count_q <= 16'h0000;
    else if (run)  // Frozen count lets the bench predict captures
      count_q <= count_q + 16'h0001;
    div_q       <= rst ? 3'h0 : div_q + 3'h1;
    periodEvent <= !rst && (div_q == 3'h7);
  end
endmodule

// ==== tb.sv ====
// Self-checking bench for the two-unit timer sharing block.
// Assumes the shared timer model on the far side and AXI4-Lite tasks here.
`timescale 1ns/100ps
`include "ccp_share_map.svh"
module tb;
  import ccp_share_pkg::*;
  logic        clk, rst, run, clr, unitOnePinIn, unitTwoPinIn;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, pwmPeriodEvent, unitOnePinOut;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp, brsp, timerGroupOne, timerGroupTwo;
  logic [15:0] sharedCaptureTimer;
  logic        portCAltPinOut, portBAltPinOut, firstTimerReset, convStart;
  logic        pwmPeriodUpdate, irq;
  logic [5:0]  obs;
  int          miscompares, checks_done;
  assign obs = {portCAltPinOut, pwmPeriodUpdate, portBAltPinOut, unitOnePinOut, irq,
                firstTimerReset};
  ccp_timer_resource_share u_dut (.clk, .rst, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .sharedCaptureTimer, .pwmPeriodEvent, .unitOnePinIn, .unitTwoPinIn, .unitOnePinOut,
    .portCAltPinOut, .portBAltPinOut, .firstTimerReset, .convStart, .pwmPeriodUpdate,
    .timerGroupOne, .timerGroupTwo, .irq);
  shared_timer_model u_timers (.clk, .rst, .run, .clr, .timerReset(firstTimerReset),
    .timerCount(sharedCaptureTimer), .periodEvent(pwmPeriodEvent));
  task automatic results();
    if (miscompares == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic chkBit(input string what, input logic exp, input logic got);
    chk(what, {31'h0, exp}, {31'h0, got});
  endtask
  task automatic hang(input string what);
    chk(what, 32'h1, 32'h0);
    results();
  endtask
  // Nonblocking drives after the rising edge keep two accesses from touching a strobe in one time step
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      n++;
    end
    while (s_axi_bvalid !== 1'b1 && n < 40);
    s_axi_bready <= 1'b0;
    brsp = s_axi_bresp;
    if (s_axi_bvalid !== 1'b1) hang("write response");
    @(posedge clk);
  endtask
  task automatic rdr(input logic [7:0] a);
    int n;
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      n++;
    end
    while (s_axi_rvalid !== 1'b1 && n < 40);
    s_axi_rready <= 1'b0;
    rd  = s_axi_rdata;
    rsp = s_axi_rresp;
    if (s_axi_rvalid !== 1'b1) hang("read response");
    @(posedge clk);
  endtask
  task automatic rc(input string what, input logic [7:0] a, input logic [31:0] exp);
    rdr(a);
    chk(what, exp, rd);
  endtask
  task automatic waitFor(input string what, input int i);
    int n;
    for (n = 0; n < 600 && obs[i] !== 1'b1; n++)
      @(posedge clk);
    if (obs[i] !== 1'b1) hang(what);
    chkBit(what, 1'b1, obs[i]);
  endtask
  task automatic pulseClr();
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
  endtask
  task automatic sReset();
    rc("config", `OFF_CONFIG, 32'h1);
    rc("unit one control", `OFF_U1_CTRL, 32'h0);
    rdr(8'h30);
    chk("unmapped resp", {30'h0, `RESP_SLVERR}, {30'h0, rsp});
    chk("unmapped data", 32'h0, rd);
    wr(8'h30, 32'h0);
    chk("unmapped write resp", {30'h0, `RESP_SLVERR}, {30'h0, brsp});
  endtask
  task automatic sRegs();
    wr(`OFF_U1_LOW, 32'hFFFFFF3C);
    chk("write resp", {30'h0, `RESP_OKAY}, {30'h0, brsp});
    wr(`OFF_U1_HIGH, 32'hC3);
    wr(`OFF_U2_LOW, 32'h5A);
    wr(`OFF_U2_HIGH, 32'hA5);
    rc("unit one low", `OFF_U1_LOW, 32'h3C);
    rc("unit one high", `OFF_U1_HIGH, 32'hC3);
    rc("unit two low", `OFF_U2_LOW, 32'h5A);
    rc("unit two high", `OFF_U2_HIGH, 32'hA5);
  endtask
  task automatic sGroups();
    wr(`OFF_U1_CTRL, 32'h4);
    wr(`OFF_U2_CTRL, 32'hC);
    rc("unit two control", `OFF_U2_CTRL, 32'hC);
    chk("group one", 32'h1, {30'h0, timerGroupOne});
    chk("group two", 32'h2, {30'h0, timerGroupTwo});
    wr(`OFF_U1_CTRL, 32'hC);
    chk("group one pwm", 32'h2, {30'h0, timerGroupOne});
    waitFor("period update", 4);
    wr(`OFF_U1_CTRL, 32'h0);
    wr(`OFF_U2_CTRL, 32'h0);
  endtask
  task automatic sSpecial();
    wr(`OFF_U2_LOW, 32'h20);
    wr(`OFF_U2_HIGH, 32'h0);
    wr(`OFF_U2_CTRL, 32'hB);
    wr(`OFF_CONFIG, 32'h3);
    wr(`OFF_IRQ_STAT, 32'h3);
    pulseClr();
    waitFor("timer reset", 0);
    chkBit("conversion start", 1'b1, convStart);
    rc("status", `OFF_IRQ_STAT, 32'h2);
    wr(`OFF_CONFIG, 32'h1);
    waitFor("timer reset", 0);
    chkBit("conversion idle", 1'b0, convStart);
    wr(`OFF_U1_LOW, 32'h20);
    wr(`OFF_U1_HIGH, 32'h0);
    wr(`OFF_U1_CTRL, 32'hB);
    wr(`OFF_IRQ_STAT, 32'h3);
    waitFor("timer reset", 0);
    rc("both flags", `OFF_IRQ_STAT, 32'h3);
  endtask
  task automatic sSoftIrq();
    wr(`OFF_U2_CTRL, 32'h0);
    wr(`OFF_U1_LOW, 32'h40);
    wr(`OFF_U1_CTRL, 32'hA);
    pulseClr();
    wr(`OFF_IRQ_STAT, 32'h3);
    wr(`OFF_IRQ_MASK, 32'h1);
    waitFor("irq", 1);
    chkBit("unit one pin", 1'b0, unitOnePinOut);
    wr(`OFF_IRQ_STAT, 32'h1);
    repeat (2) @(posedge clk);
    chkBit("irq cleared", 1'b0, irq);
  endtask
  task automatic sSetHigh();
    wr(`OFF_U1_CTRL, 32'h8);
    pulseClr();
    waitFor("unit one pin", 2);
    wr(`OFF_U2_LOW, 32'h40);
    wr(`OFF_CONFIG, 32'h0);  // Software owns pin direction
    wr(`OFF_U2_CTRL, 32'h8);
    pulseClr();
    waitFor("port b pin", 3);
    chkBit("port c pin", 1'b0, portCAltPinOut);
  endtask
  task automatic sCapture();
    wr(`OFF_U1_CTRL, 32'h5);
    wr(`OFF_U2_CTRL, 32'h5);
    wr(`OFF_CONFIG, 32'h5);
    wr(`OFF_IRQ_MASK, 32'h3);
    wr(`OFF_IRQ_STAT, 32'h3);
    run          <= 1'b0;
    unitOnePinIn <= 1'b1;
    unitTwoPinIn <= 1'b1;
    repeat (8) @(posedge clk);
    chkBit("async capture irq", 1'b0, irq);
    unitOnePinIn <= 1'b0;
    unitTwoPinIn <= 1'b0;
    wr(`OFF_CONFIG, 32'h1);
    unitOnePinIn <= 1'b1;
    unitTwoPinIn <= 1'b1;
    waitFor("capture irq", 1);
    rc("capture one low", `OFF_U1_LOW, {24'h0, sharedCaptureTimer[7:0]});
    rc("capture one high", `OFF_U1_HIGH, {24'h0, sharedCaptureTimer[15:8]});
    rc("capture two low", `OFF_U2_LOW, {24'h0, sharedCaptureTimer[7:0]});
    rc("capture two high", `OFF_U2_HIGH, {24'h0, sharedCaptureTimer[15:8]});
  endtask
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial
  begin
    {rst, run} = 2'b11;
    {clr, unitOnePinIn, unitTwoPinIn} = 3'h0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    s_axi_wstrb = 4'hF;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    sReset();
    sRegs();
    sGroups();
    sSpecial();
    sSoftIrq();
    sSetHigh();
    sCapture();
    results();
  end
endmodule
